//--- peci_status_defines.vh
// Constants for the PECI host status register slice
`ifndef PECI_STATUS_DEFINES_VH
`define PECI_STATUS_DEFINES_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_HOST_CTRL 8'hE5
`define IDX_WARN_FLAGS 8'hE8
`define IDX_SST_ADDR 8'hF1
`define IDX_INT_STATUS 8'hF8
`define IDX_INT_MASK 8'hF9
`define IDX_TEMP_HIGH 8'hFE
`define IDX_TEMP_LOW 8'hFF

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define WARN_FLAG_LSB 4
`define WARN_FLAG_MSB 7
`define WARN_SPEED_LSB 0
`define WARN_SPEED_MSB 1
`define HOST_SEL_BIT 0
`define RST_WARN_FLAGS 8'h00
`define RST_SST_ADDR 8'h48
`define RST_TEMP 8'h00
`define RST_HOST_CTRL 8'h00
`define INT_DONE_BIT 4
`define INT_WIDTH 5

// ----------------------------------------------------------------
// Link constants
// ----------------------------------------------------------------
`define CLIENT_ADDR_BASE 8'h30
`define HISTORY_DEPTH 3
`define CLK_RATE_KHZ 100000
`define PECI_FAST_KHZ 1500
// Shortest bit time, at the fast rate, rounds down to whole clock cycles
`define PECI_FAST_DIV (`CLK_RATE_KHZ / `PECI_FAST_KHZ)

// ----------------------------------------------------------------
// AXI4-Lite responses
// ----------------------------------------------------------------
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

//--- agent_health.v
// Per-agent transaction history and absent/alert flag
module agent_health #(
   parameter DEPTH = 3
) (
   input wire clk_i,
   input wire rst_b_i,
   input wire update_i,
   input wire good_i,
   output wire alert_o
);

   reg [DEPTH-1:0] history_ff;
   wire [DEPTH-1:0] nxt_history;

   // ----------------------------------------------------------------
   // Sliding window of recent outcomes, one bit per transaction
   // ----------------------------------------------------------------
   // A one marks a failed transaction: no answer or a bad FCS
   assign nxt_history = {history_ff[DEPTH-2:0], ~good_i}; // RULE13

   // Shift only when this agent finished a transaction
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         history_ff <= {DEPTH{1'b0}};
      end else if (update_i) begin
         history_ff <= nxt_history;
      end
   end

   // Any failure in the window raises the flag; clean window clears it
   assign alert_o = |history_ff; // RULE2 RULE3

endmodule

//--- peci_status_regs.v
// PECI host status registers with AXI4-Lite slave and rate divider
//
// Chosen here: the AXI4-Lite register port.
`include "peci_status_defines.vh"

// Functional notes
// RULE1 - Four absent/alert flags sit in warning bits 4..7, agent 1 lowest.
// RULE2 - Flag is one if agent missed or gave bad FCS in last three.
// RULE3 - Flag stays zero while agent answers with correct FCS.
// RULE4 - Two-bit speed field picks 1.5 MHz, 750, 375 or 187.5 KHz.
// RULE5 - Warning register reads zero after reset, fastest rate selected.
// RULE6 - Eight-bit read/write SST target address, resets to 48 hex.
// RULE7 - Read-only high byte of retrieved raw word, resets to zero.
// RULE8 - Read-only low byte of retrieved raw word, resets to zero.
// RULE9 - Retrieved word is signed 16-bit, LSB equals 1/64 degree C.
// RULE10 - Agents one to four use client addresses 30 to 33 hex.
// RULE11 - Host-select bit chooses this device or another as link host.
// RULE12 - Both temperature bytes update together after a good transaction.
// RULE13 - Each flag judges that agent's three most recent transactions.
module peci_status_regs #(
   parameter ADDR_W = 12,
   parameter AGENTS = 4
) (
   input wire SYS_CLK_I,
   input wire RST_B_I,
   // AXI4-Lite write address
   input wire [ADDR_W-1:0] S_AXI_AWADDR_I,
   input wire [2:0] S_AXI_AWPROT_I,
   input wire S_AXI_AWVALID_I,
   output wire S_AXI_AWREADY_O,
   // AXI4-Lite write data
   input wire [31:0] S_AXI_WDATA_I,
   input wire [3:0] S_AXI_WSTRB_I,
   input wire S_AXI_WVALID_I,
   output wire S_AXI_WREADY_O,
   // AXI4-Lite write response
   output wire [1:0] S_AXI_BRESP_O,
   output wire S_AXI_BVALID_O,
   input wire S_AXI_BREADY_I,
   // AXI4-Lite read address
   input wire [ADDR_W-1:0] S_AXI_ARADDR_I,
   input wire [2:0] S_AXI_ARPROT_I,
   input wire S_AXI_ARVALID_I,
   output wire S_AXI_ARREADY_O,
   // AXI4-Lite read data
   output wire [31:0] S_AXI_RDATA_O,
   output wire [1:0] S_AXI_RRESP_O,
   output wire S_AXI_RVALID_O,
   input wire S_AXI_RREADY_I,
   // Transaction engine side
   input wire [1:0] AGENT_SEL_I,
   input wire XFER_DONE_I,
   input wire [1:0] XFER_AGENT_I,
   input wire XFER_GOOD_I,
   input wire [15:0] XFER_DATA_I,
   output wire [7:0] CLIENT_ADDR_O,
   output wire BIT_EN_O,
   output wire HOST_ACTIVE_O,
   output wire [7:0] SST_ADDR_O,
   output wire [15:0] REL_TEMP_O,
   output wire TEMP_BELOW_ZERO_O,
   output wire IRQ_O
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   reg [1:0] speed_ff;
   reg [7:0] sst_addr_ff;
   reg [7:0] temp_high_ff;
   reg [7:0] temp_low_ff;
   reg host_sel_ff;
   reg [`INT_WIDTH-1:0] int_status_ff;
   reg [`INT_WIDTH-1:0] int_mask_ff;
   reg [7:0] client_addr_ff;
   wire [AGENTS-1:0] alert;
   reg [AGENTS-1:0] alert_prev_ff;

   // ----------------------------------------------------------------
   // Write channel state
   // ----------------------------------------------------------------
   reg aw_held_ff;
   reg [ADDR_W-1:0] aw_addr_ff;
   reg w_held_ff;
   reg [31:0] w_data_ff;
   reg [3:0] w_strb_ff;
   reg bvalid_ff;
   reg [1:0] bresp_ff;

   // ----------------------------------------------------------------
   // Read channel state
   // ----------------------------------------------------------------
   reg rvalid_ff;
   reg [31:0] rdata_ff;
   reg [1:0] rresp_ff;

   // ----------------------------------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------------------------------
   // Address and data may arrive in either order; each is held alone
   assign S_AXI_AWREADY_O = ~aw_held_ff & ~bvalid_ff;
   assign S_AXI_WREADY_O = ~w_held_ff & ~bvalid_ff;

   wire aw_take = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
   wire w_take = S_AXI_WVALID_I & S_AXI_WREADY_O;
   wire have_aw = aw_held_ff | aw_take;
   wire have_w = w_held_ff | w_take;
   wire wr_fire = have_aw & have_w & ~bvalid_ff;
   wire [ADDR_W-1:0] wr_addr = aw_held_ff ? aw_addr_ff : S_AXI_AWADDR_I;
   wire [31:0] wr_data = w_held_ff ? w_data_ff : S_AXI_WDATA_I;
   wire [3:0] wr_strb = w_held_ff ? w_strb_ff : S_AXI_WSTRB_I;
   wire [7:0] wr_idx = wr_addr[9:2];
   wire wr_aligned = (wr_addr[1:0] == 2'h0) & (wr_addr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}});
   // Registers are one byte wide, so only lane 0 carries a change
   wire wr_lane0 = wr_fire & wr_aligned & wr_strb[0];
   wire [7:0] wr_byte = wr_data[7:0];

   // Decode of the write target
   reg wr_hit;
   always @* begin
      case (wr_idx)
         `IDX_HOST_CTRL, `IDX_WARN_FLAGS, `IDX_SST_ADDR, `IDX_INT_STATUS, `IDX_INT_MASK,
         `IDX_TEMP_HIGH, `IDX_TEMP_LOW: begin
            wr_hit = wr_aligned;
         end
         default: begin
            wr_hit = 1'b0;
         end
      endcase
   end

   // Channel bookkeeping and the single response
   always @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         aw_held_ff <= 1'b0;
         aw_addr_ff <= {ADDR_W{1'b0}};
         w_held_ff <= 1'b0;
         w_data_ff <= 32'h00000000;
         w_strb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `AXI_RESP_OKAY;
      end else begin
         if (wr_fire) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
         end else begin
            if (aw_take) begin
               aw_held_ff <= 1'b1;
               aw_addr_ff <= S_AXI_AWADDR_I;
            end
            if (w_take) begin
               w_held_ff <= 1'b1;
               w_data_ff <= S_AXI_WDATA_I;
               w_strb_ff <= S_AXI_WSTRB_I;
            end
            if (bvalid_ff && S_AXI_BREADY_I) begin
               bvalid_ff <= 1'b0;
            end
         end
      end
   end

   assign S_AXI_BVALID_O = bvalid_ff;
   assign S_AXI_BRESP_O = bresp_ff;

   // ----------------------------------------------------------------
   // Software-written configuration
   // ----------------------------------------------------------------
   // Flag bits of the warning register follow the history, not writes
   always @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         speed_ff <= 2'h0; // RULE5
         sst_addr_ff <= `RST_SST_ADDR; // RULE6
         host_sel_ff <= 1'b0;
         int_mask_ff <= {`INT_WIDTH{1'b0}};
      end else if (wr_lane0) begin
         case (wr_idx)
            `IDX_WARN_FLAGS: begin
               speed_ff <= wr_byte[`WARN_SPEED_MSB:`WARN_SPEED_LSB]; // RULE4
            end
            `IDX_SST_ADDR: begin
               sst_addr_ff <= wr_byte; // RULE6
            end
            `IDX_HOST_CTRL: begin
               host_sel_ff <= wr_byte[`HOST_SEL_BIT]; // RULE11
            end
            `IDX_INT_MASK: begin
               int_mask_ff <= wr_byte[`INT_WIDTH-1:0];
            end
            default: begin
               int_mask_ff <= int_mask_ff;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Link host selection
   // ----------------------------------------------------------------
   // With another controller hosting, no bit timing and no results here
   assign HOST_ACTIVE_O = ~host_sel_ff; // RULE11
   wire result_ok = XFER_DONE_I & ~host_sel_ff;

   // ----------------------------------------------------------------
   // Bit-rate enable divider
   // ----------------------------------------------------------------
   // Each step of the speed field doubles the bit time
   // Integer quotient narrowed on purpose; the slowest rate still fits 16 bits
   localparam integer FAST_DIV_INT = `PECI_FAST_DIV;
   localparam [15:0] FAST_DIV = FAST_DIV_INT[15:0];
   reg [15:0] rate_cnt_ff;
   wire [15:0] rate_top = (FAST_DIV << speed_ff) - 16'h0001; // RULE4
   wire rate_hit = (rate_cnt_ff >= rate_top);
   reg bit_en_ff;

   // A lowered rate top is never overrun because the compare is >=; a raised one just counts on
   always @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         rate_cnt_ff <= 16'h0000;
         bit_en_ff <= 1'b0;
      end else if (host_sel_ff) begin
         rate_cnt_ff <= 16'h0000;
         bit_en_ff <= 1'b0;
      end else begin
         rate_cnt_ff <= rate_hit ? 16'h0000 : rate_cnt_ff + 16'h0001;
         bit_en_ff <= rate_hit; // RULE4
      end
   end

   assign BIT_EN_O = bit_en_ff;

   // ----------------------------------------------------------------
   // Client addressing
   // ----------------------------------------------------------------
   // Agent n talks at base plus n-1
   always @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         client_addr_ff <= `CLIENT_ADDR_BASE;
      end else begin
         client_addr_ff <= `CLIENT_ADDR_BASE + {6'h00, AGENT_SEL_I}; // RULE10
      end
   end

   assign CLIENT_ADDR_O = client_addr_ff;

   // ----------------------------------------------------------------
   // Per-agent health trackers
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < AGENTS; g = g + 1) begin : agent_track
         agent_health #(
            .DEPTH(`HISTORY_DEPTH)
         ) u_health (
            .clk_i(SYS_CLK_I),
            .rst_b_i(RST_B_I),
            .update_i(result_ok & (XFER_AGENT_I == g)), // RULE13
            .good_i(XFER_GOOD_I),
            .alert_o(alert[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Retrieved temperature word
   // ----------------------------------------------------------------
   // One write for both bytes keeps a high/low pair from one transaction
   always @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         temp_high_ff <= `RST_TEMP; // RULE7
         temp_low_ff <= `RST_TEMP; // RULE8
      end else if (result_ok && XFER_GOOD_I) begin
         temp_high_ff <= XFER_DATA_I[15:8]; // RULE7 RULE12
         temp_low_ff <= XFER_DATA_I[7:0]; // RULE8 RULE12
      end
   end

   // Signed word in 1/64 degree steps; the sign bit flags sub-zero
   assign REL_TEMP_O = {temp_high_ff, temp_low_ff}; // RULE9
   assign TEMP_BELOW_ZERO_O = temp_high_ff[7]; // RULE9
   assign SST_ADDR_O = sst_addr_ff;

   // ----------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------
   // Events: a flag rising per agent, and each transaction finished while this device hosts
   wire [`INT_WIDTH-1:0] int_event = {result_ok, alert & ~alert_prev_ff};
   wire [`INT_WIDTH-1:0] int_clear = (wr_lane0 && wr_idx == `IDX_INT_STATUS) ?
      wr_byte[`INT_WIDTH-1:0] : {`INT_WIDTH{1'b0}};

   // A new event in the clearing cycle is kept: set beats clear
   always @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         int_status_ff <= {`INT_WIDTH{1'b0}};
         alert_prev_ff <= {AGENTS{1'b0}};
      end else begin
         int_status_ff <= (int_status_ff & ~int_clear) | int_event;
         alert_prev_ff <= alert;
      end
   end

   assign IRQ_O = |(int_status_ff & int_mask_ff);

   // ----------------------------------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------------------------------
   wire [7:0] rd_idx = S_AXI_ARADDR_I[9:2];
   wire rd_aligned = (S_AXI_ARADDR_I[1:0] == 2'h0) &
      (S_AXI_ARADDR_I[ADDR_W-1:10] == {(ADDR_W-10){1'b0}});
   assign S_AXI_ARREADY_O = ~rvalid_ff;
   wire rd_take = S_AXI_ARVALID_I & S_AXI_ARREADY_O;

   // Read mux; reserved bits and upper bytes read as zero
   reg [7:0] rd_byte;
   reg rd_hit;
   always @* begin
      rd_byte = 8'h00;
      rd_hit = rd_aligned;
      case (rd_idx)
         `IDX_WARN_FLAGS: begin
            rd_byte = {alert, 2'h0, speed_ff}; // RULE1
         end
         `IDX_SST_ADDR: begin
            rd_byte = sst_addr_ff;
         end
         `IDX_TEMP_HIGH: begin
            rd_byte = temp_high_ff;
         end
         `IDX_TEMP_LOW: begin
            rd_byte = temp_low_ff;
         end
         `IDX_HOST_CTRL: begin
            rd_byte = {7'h00, host_sel_ff};
         end
         `IDX_INT_STATUS: begin
            rd_byte = {3'h0, int_status_ff};
         end
         `IDX_INT_MASK: begin
            rd_byte = {3'h0, int_mask_ff};
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   // One read in flight; answer one cycle after the address is taken
   always @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= `AXI_RESP_OKAY;
      end else if (rd_take) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_hit ? {24'h000000, rd_byte} : 32'h00000000;
         rresp_ff <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (rvalid_ff && S_AXI_RREADY_I) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign S_AXI_RVALID_O = rvalid_ff;
   assign S_AXI_RDATA_O = rdata_ff;
   assign S_AXI_RRESP_O = rresp_ff;

endmodule

//--- peci_status_regs_sva.sv
// Concurrent checks on the PECI status register slice ports
module peci_status_regs_sva (
   input wire SYS_CLK_I,
   input wire RST_B_I,
   input wire [1:0] AGENT_SEL_I,
   input wire [7:0] CLIENT_ADDR_O,
   input wire XFER_DONE_I,
   input wire XFER_GOOD_I,
   input wire [15:0] XFER_DATA_I,
   input wire HOST_ACTIVE_O,
   input wire [15:0] REL_TEMP_O,
   input wire TEMP_BELOW_ZERO_O,
   input wire BIT_EN_O,
   input wire S_AXI_ARVALID_I,
   input wire S_AXI_ARREADY_O,
   input wire S_AXI_RVALID_O,
   input wire S_AXI_RREADY_I,
   input wire S_AXI_BVALID_O,
   input wire S_AXI_BREADY_I,
   input wire [1:0] S_AXI_BRESP_O
);
   // ----------------------------------------
   // Bit strobe gap counter
   // ----------------------------------------
   logic [9:0] gap_ff;
   logic seen_ff;
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_B_I);
   // Saturates so a stopped divider never wraps into a false short gap
   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         gap_ff <= 10'h000;
         seen_ff <= 1'b0;
      end else begin
         gap_ff <= BIT_EN_O ? 10'h001 : (gap_ff == 10'h3FF) ? gap_ff : gap_ff + 10'h001;
         seen_ff <= seen_ff | BIT_EN_O;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   client_addr_a: assert property (1'b1 |=> CLIENT_ADDR_O == 8'h30 + $past(AGENT_SEL_I))
      else $error("client address does not follow agent select");
   temp_load_a: assert property (XFER_DONE_I && XFER_GOOD_I && HOST_ACTIVE_O
      |=> REL_TEMP_O == $past(XFER_DATA_I)) else $error("temperature word not captured");
   temp_keep_a: assert property (!(XFER_DONE_I && XFER_GOOD_I) |=> $stable(REL_TEMP_O))
      else $error("temperature changed without good transfer");
   sign_bit_a: assert property (XFER_DONE_I && XFER_GOOD_I && HOST_ACTIVE_O
      |=> TEMP_BELOW_ZERO_O == $past(XFER_DATA_I[15]))
      else $error("sign flag disagrees with word");
   read_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
      else $error("read data late");
   rvalid_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O)
      else $error("read data dropped");
   bvalid_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
      |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("write response dropped");
   host_quiet_a: assert property (!HOST_ACTIVE_O && !$past(HOST_ACTIVE_O) |-> !BIT_EN_O)
      else $error("bit strobe while other host owns link");
   bit_gap_a: assert property (BIT_EN_O && seen_ff |-> gap_ff >= 10'h042)
      else $error("bit strobes too close");
endmodule

bind peci_status_regs peci_status_regs_sva chk (.SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I),
   .AGENT_SEL_I(AGENT_SEL_I), .CLIENT_ADDR_O(CLIENT_ADDR_O), .XFER_DONE_I(XFER_DONE_I),
   .XFER_GOOD_I(XFER_GOOD_I), .XFER_DATA_I(XFER_DATA_I), .HOST_ACTIVE_O(HOST_ACTIVE_O),
   .REL_TEMP_O(REL_TEMP_O), .TEMP_BELOW_ZERO_O(TEMP_BELOW_ZERO_O), .BIT_EN_O(BIT_EN_O),
   .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
   .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
   .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
   .S_AXI_BRESP_O(S_AXI_BRESP_O));

//--- peci_agent_model.sv
// Behavioural client agents answering transactions with a chosen delay
module peci_agent_model (
   input wire clk_i,
   input wire rst_b_i,
   input wire go_i,
   input wire [1:0] agent_i,
   input wire good_i,
   input wire [15:0] word_i,
   input wire [3:0] wait_i,
   output logic done_o,
   output logic [1:0] agent_o,
   output logic good_o,
   output logic [15:0] data_o,
   output logic busy_o
);
   logic [3:0] cnt_ff;
   // Lines are scrambled after the answer so stale values never look valid
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_ff <= 4'h0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         agent_o <= 2'h0;
         good_o <= 1'b0;
         data_o <= 16'h0000;
      end else if (go_i && !busy_o) begin
         busy_o <= 1'b1;
         cnt_ff <= wait_i;
         done_o <= 1'b0;
         agent_o <= agent_i;
         good_o <= good_i;
         data_o <= word_i;
      end else if (busy_o && cnt_ff == 4'h0) begin
         done_o <= 1'b1;
         busy_o <= 1'b0;
      end else if (busy_o) begin
         cnt_ff <= cnt_ff - 4'h1;
      end else if (done_o) begin
         done_o <= 1'b0;
         agent_o <= ~agent_o;
         good_o <= ~good_o;
         data_o <= ~data_o;
      end
   end
endmodule

//--- test_peci_status_regs.sv
// Self-checking bench for the PECI status register slice
`include "peci_status_defines.vh"
module test_peci_status_regs;
   timeunit 1ns;
   timeprecision 1ns;
   localparam [11:0] A_WARN = {2'b00, `IDX_WARN_FLAGS, 2'b00};
   localparam [11:0] A_SST = {2'b00, `IDX_SST_ADDR, 2'b00};
   localparam [11:0] A_TH = {2'b00, `IDX_TEMP_HIGH, 2'b00};
   localparam [11:0] A_TL = {2'b00, `IDX_TEMP_LOW, 2'b00};
   localparam [11:0] A_HC = {2'b00, `IDX_HOST_CTRL, 2'b00};
   localparam [11:0] A_IS = {2'b00, `IDX_INT_STATUS, 2'b00};
   localparam [11:0] A_IM = {2'b00, `IDX_INT_MASK, 2'b00};
   logic clk = 0, rst_b = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic [1:0] sel = 0, gagt = 0;
   logic go = 0, ggood = 0;
   logic [15:0] gword = 0;
   logic [3:0] gwait = 0;
   wire awready, wready, bvalid, arready, rvalid, xdone, xgood, biten, hact, neg, irq, busy;
   wire [1:0] bresp, rresp, xagt;
   wire [31:0] rdata;
   wire [15:0] xdata, temp;
   wire [7:0] cadr, sst;
   int errors = 0, compares = 0, cyc = 0;
   always #5 clk = ~clk;
   // ----------------------------------------
   // Design and far-side agents
   // ----------------------------------------
   peci_status_regs dut (.SYS_CLK_I(clk), .RST_B_I(rst_b), .S_AXI_AWADDR_I(awaddr),
      .S_AXI_AWPROT_I(3'h0), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
      .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
      .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
      .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARPROT_I(3'h0),
      .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
      .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
      .AGENT_SEL_I(sel), .XFER_DONE_I(xdone), .XFER_AGENT_I(xagt), .XFER_GOOD_I(xgood),
      .XFER_DATA_I(xdata), .CLIENT_ADDR_O(cadr), .BIT_EN_O(biten), .HOST_ACTIVE_O(hact),
      .SST_ADDR_O(sst), .REL_TEMP_O(temp), .TEMP_BELOW_ZERO_O(neg), .IRQ_O(irq));
   peci_agent_model agents (.clk_i(clk), .rst_b_i(rst_b), .go_i(go), .agent_i(gagt),
      .good_i(ggood), .word_i(gword), .wait_i(gwait), .done_o(xdone), .agent_o(xagt),
      .good_o(xgood), .data_o(xdata), .busy_o(busy));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task give_verdict;
      $display("comparisons %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Write: address and data offered together, each dropped once taken
   task wr(input [11:0] a, input [7:0] d, input [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && n < 100);
      bready <= 1'b0;
      chk(bvalid, 1'b1);
      chk(bresp, er);
   endtask
   task rd(input [11:0] a, input [7:0] e, input [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid && n < 100);
      rready <= 1'b0;
      chk(rvalid, 1'b1);
      chk(rdata, {24'h000000, e});
      chk(rresp, er);
   endtask
   // One agent transaction, then two edges so flags and interrupt settle
   task xf(input [1:0] a, input g, input [15:0] w, input [3:0] dl);
      int n;
      n = 0;
      @(posedge clk);
      go <= 1'b1;
      gagt <= a;
      ggood <= g;
      gword <= w;
      gwait <= dl;
      @(posedge clk);
      go <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (!xdone && n < 40);
      chk(xdone, 1'b1);
      repeat (2) @(posedge clk);
   endtask
   // First two gaps only resynchronise after a rate change
   task gap(input [9:0] e);
      int n;
      for (int k = 0; k < 3; k++) begin
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (!biten && n < 2000);
      end
      chk(n, e);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         give_verdict;
      end
   end
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      rd(A_WARN, 8'h00, 2'h0);
      rd(A_SST, 8'h48, 2'h0);
      rd(A_TH, 8'h00, 2'h0);
      rd(A_TL, 8'h00, 2'h0);
      rd(12'h000, 8'h00, 2'h2);
      chk(hact, 1'b1);
      $display("test reset done");
      wr(A_SST, 8'hA5, 2'h0);
      rd(A_SST, 8'hA5, 2'h0);
      chk(sst, 8'hA5);
      wr(A_TH, 8'h5A, 2'h0);
      wr(A_TL, 8'h5A, 2'h0);
      rd(A_TH, 8'h00, 2'h0);
      rd(A_TL, 8'h00, 2'h0);
      wr(A_WARN, 8'hFF, 2'h0);
      rd(A_WARN, 8'h03, 2'h0);
      wr(12'h004, 8'h11, 2'h2);
      $display("test access done");
      for (int s = 0; s < 4; s++) begin
         wr(A_WARN, 8'(s), 2'h0);
         gap(10'h042 << s);
      end
      wr(A_WARN, 8'h00, 2'h0);
      $display("test speed done");
      wr(A_IM, 8'h01, 2'h0);
      for (int a = 0; a < 4; a++) begin
         sel <= a[1:0];
         xf(a[1:0], 1'b0, 16'h1111, 4'h0);
         chk(cadr, 8'h30 + a);
         rd(A_WARN, 8'h10 << a, 2'h0);
         chk(irq, a == 0);
         rd(A_IS, 8'h10 | (8'h01 << a), 2'h0);
         wr(A_IS, 8'h1F, 2'h0);
         chk(irq, 1'b0);
         repeat (2) begin
            xf(a[1:0], 1'b1, 16'h2222, 4'hF);
            rd(A_WARN, 8'h10 << a, 2'h0);
         end
         xf(a[1:0], 1'b1, 16'h2222, 4'h3);
         rd(A_WARN, 8'h00, 2'h0);
      end
      chk(temp, 16'h2222);
      chk(neg, 1'b0);
      $display("test agents done");
      xf(2'h1, 1'b1, 16'hFF80, 4'h9);
      rd(A_TH, 8'hFF, 2'h0);
      rd(A_TL, 8'h80, 2'h0);
      chk(neg, 1'b1);
      xf(2'h2, 1'b0, 16'h1234, 4'h0);
      chk(temp, 16'hFF80);
      $display("test temperature done");
      wr(A_HC, 8'h01, 2'h0);
      chk(hact, 1'b0);
      xf(2'h3, 1'b0, 16'h0F0F, 4'h0);
      rd(A_WARN, 8'h40, 2'h0);
      wr(A_HC, 8'h00, 2'h0);
      chk(hact, 1'b1);
      $display("test host done");
      give_verdict;
   end
endmodule
